// ===== verilog/serdes_status_pkg.sv
// Purpose: Shared constants for the transceiver status register bank.
// Assumes: 18-bit system address, 8-bit registers on data bits 0 to 7.
// Notes: Field bit n of a register sits on data bit n.
package serdes_status_pkg;

  // ****************************************
  // Bus geometry
  // ****************************************
  localparam int ADDR_W = 18;
  localparam int DATA_W = 8;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [17:0] QUAD_A_LINK_SYNC_STATE = 18'h30804;
  localparam logic [17:0] QUAD_A_ALIGNMENT_STATUS = 18'h30805;
  localparam logic [17:0] QUAD_A_PAIR_SYNC_STATUS = 18'h30814;
  localparam logic [17:0] QUAD_B_LINK_SYNC_STATE = 18'h30904;
  localparam logic [17:0] QUAD_B_ALIGNMENT_STATUS = 18'h30905;
  localparam logic [17:0] QUAD_B_PAIR_SYNC_STATUS = 18'h30914;
  localparam logic [17:0] QUAD_B_SPARE = 18'h30933;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int LINK_SYNC_FIRST_LO = 4;
  localparam int LINK_SYNC_SECOND_LO = 6;
  localparam int WORD_ALIGN_FIRST_BIT = 2;
  localparam int WORD_ALIGN_SECOND_BIT = 3;
  localparam int LANE_ALIGN_FIRST_BIT = 6;
  localparam int LANE_ALIGN_SECOND_BIT = 7;
  localparam int PAIR_OVERFLOW_BIT = 1;
  localparam int PAIR_SYNC_LOST_BIT = 4;

  // ****************************************
  // Link sync codes, first digit on lower bit
  // ****************************************
  localparam logic [1:0] SYNC_NONE = 2'h0;
  localparam logic [1:0] SYNC_DONE = 2'h1;
  localparam logic [1:0] SYNC_NO_COMMA_CV = 2'h2;
  localparam logic [1:0] SYNC_UNUSED = 2'h3;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [1:0] SYNC_RESET = 2'h0;

  // ****************************************
  // Register selection
  // ****************************************
  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_A_SYNC = 3'h1,
    SEL_A_ALIGN = 3'h2,
    SEL_A_PAIR = 3'h3,
    SEL_B_SYNC = 3'h4,
    SEL_B_ALIGN = 3'h5,
    SEL_B_PAIR = 3'h6,
    SEL_B_SPARE = 3'h7
  } reg_sel_t;

endpackage : serdes_status_pkg

// ===== verilog/quad_status_capture.sv
// Purpose: Sticky clear-on-read status flags of one transceiver quad.
// Assumes: Status inputs come from logic on clk_sys.
// Notes: A new event in the clearing cycle survives the clear.
`timescale 1ns/1ps
module quad_status_capture (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [1:0] link_sync_state_first,
  input wire logic [1:0] link_sync_state_second,
  input wire logic word_align_ok_first,
  input wire logic word_align_ok_second,
  input wire logic lane_align_ok_first,
  input wire logic lane_align_ok_second,
  input wire logic pair_fifo_overflow,
  input wire logic pair_sync_lost,
  input wire logic clear_sync,
  input wire logic clear_align,
  input wire logic clear_pair,
  output logic [7:0] sync_value,
  output logic [7:0] align_value,
  output logic [7:0] pair_value
);

  logic [1:0] sync_first;
  logic [1:0] sync_second;
  logic [1:0] next_sync_first;
  logic [1:0] next_sync_second;
  logic [3:0] align_flags;
  logic [3:0] next_align_flags;
  logic [1:0] pair_flags;
  logic [1:0] next_pair_flags;

  // Latest reported code wins; unused code never reported
  function automatic logic [1:0] next_code(input logic [1:0] held, input logic [1:0] live,
                                           input logic clr);
    logic [1:0] result;
    result = clr ? serdes_status_pkg::SYNC_RESET : held;
    if (live != serdes_status_pkg::SYNC_NONE && live != serdes_status_pkg::SYNC_UNUSED) begin
      result = live;
    end
    return result;
  endfunction : next_code

  // ****************************************
  // Next values
  // ****************************************
  always_comb begin
    next_sync_first = next_code(sync_first, link_sync_state_first, clear_sync);
    next_sync_second = next_code(sync_second, link_sync_state_second, clear_sync);
    next_align_flags = (clear_align ? 4'h0 : align_flags) |
                       {lane_align_ok_second, lane_align_ok_first,
                        word_align_ok_second, word_align_ok_first};
    next_pair_flags = (clear_pair ? 2'h0 : pair_flags) |
                      {pair_sync_lost, pair_fifo_overflow};
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync_first <= serdes_status_pkg::SYNC_RESET;
      sync_second <= serdes_status_pkg::SYNC_RESET;
      align_flags <= 4'h0;
      pair_flags <= 2'h0;
    end else begin
      sync_first <= next_sync_first;
      sync_second <= next_sync_second;
      align_flags <= next_align_flags;
      pair_flags <= next_pair_flags;
    end
  end

  // ****************************************
  // Register images, reserved bits zero
  // ****************************************
  always_comb begin
    sync_value = serdes_status_pkg::STATUS_RESET;
    sync_value[serdes_status_pkg::LINK_SYNC_FIRST_LO +: 2] = sync_first;
    sync_value[serdes_status_pkg::LINK_SYNC_SECOND_LO +: 2] = sync_second;
    align_value = serdes_status_pkg::STATUS_RESET;
    align_value[serdes_status_pkg::WORD_ALIGN_FIRST_BIT] = align_flags[0];
    align_value[serdes_status_pkg::WORD_ALIGN_SECOND_BIT] = align_flags[1];
    align_value[serdes_status_pkg::LANE_ALIGN_FIRST_BIT] = align_flags[2];
    align_value[serdes_status_pkg::LANE_ALIGN_SECOND_BIT] = align_flags[3];
    pair_value = serdes_status_pkg::STATUS_RESET;
    pair_value[serdes_status_pkg::PAIR_OVERFLOW_BIT] = pair_flags[0];
    pair_value[serdes_status_pkg::PAIR_SYNC_LOST_BIT] = pair_flags[1];
  end

endmodule : quad_status_capture

// ===== verilog/port_request_latch.sv
// Purpose: Picks one of two requesting ports and holds the taken request.
// Assumes: Requests come from logic on clk_sys and stay high until acknowledged.
// Notes: Processor port has priority when both ask together.
`timescale 1ns/1ps
module port_request_latch (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic take,
  input wire logic proc_req,
  input wire logic proc_write,
  input wire logic [17:0] proc_addr,
  input wire logic fab_req,
  input wire logic fab_write,
  input wire logic [17:0] fab_addr,
  output logic any_req,
  output logic held_from_fab,
  output logic held_write,
  output logic [17:0] held_addr
);

  logic next_from_fab;
  logic next_write;
  logic [17:0] next_addr;

  // ****************************************
  // Priority choice, same address map for both
  // ****************************************
  always_comb begin
    any_req = proc_req | fab_req;
    next_from_fab = held_from_fab;
    next_write = held_write;
    next_addr = held_addr;
    if (take && proc_req) begin
      next_from_fab = 1'b0;
      next_write = proc_write;
      next_addr = proc_addr;
    end else if (take && fab_req) begin
      next_from_fab = 1'b1;
      next_write = fab_write;
      next_addr = fab_addr;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      held_from_fab <= 1'b0;
      held_write <= 1'b0;
      held_addr <= 18'h00000;
    end else begin
      held_from_fab <= next_from_fab;
      held_write <= next_write;
      held_addr <= next_addr;
    end
  end

endmodule : port_request_latch

// ===== verilog/serdes_link_status_regs.sv
// Purpose: Clear-on-read status register bank of both transceiver quads.
// Assumes: Processor and fabric master ports and status inputs run on clk_sys.
// Notes: Read data and acknowledge come straight from flops.
`timescale 1ns/1ps
module serdes_link_status_regs (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic proc_req,
  input wire logic proc_write,
  input wire logic [17:0] proc_addr,
  output logic proc_ack,
  output logic [7:0] proc_rdata,
  input wire logic fab_req,
  input wire logic fab_write,
  input wire logic [17:0] fab_addr,
  output logic fab_ack,
  output logic [7:0] fab_rdata,
  input wire logic [1:0] quad_a_link_sync_first,
  input wire logic [1:0] quad_a_link_sync_second,
  input wire logic quad_a_word_align_first,
  input wire logic quad_a_word_align_second,
  input wire logic quad_a_lane_align_first,
  input wire logic quad_a_lane_align_second,
  input wire logic quad_a_pair_fifo_overflow,
  input wire logic quad_a_pair_sync_lost,
  input wire logic [1:0] quad_b_link_sync_first,
  input wire logic [1:0] quad_b_link_sync_second,
  input wire logic quad_b_word_align_first,
  input wire logic quad_b_word_align_second,
  input wire logic quad_b_lane_align_first,
  input wire logic quad_b_lane_align_second,
  input wire logic quad_b_pair_fifo_overflow,
  input wire logic quad_b_pair_sync_lost
);

  // ****************************************
  // Access sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACCESS = 3'b010,
    ST_RELEASE = 3'b100
  } access_state_t;

  access_state_t state;
  access_state_t next_state;

  logic take;
  logic any_req;
  logic held_from_fab;
  logic held_write;
  logic [17:0] held_addr;
  serdes_status_pkg::reg_sel_t sel;

  logic [7:0] a_sync;
  logic [7:0] a_align;
  logic [7:0] a_pair;
  logic [7:0] b_sync;
  logic [7:0] b_align;
  logic [7:0] b_pair;
  logic [7:0] read_value;
  logic reading;
  logic clr_a_sync;
  logic clr_a_align;
  logic clr_a_pair;
  logic clr_b_sync;
  logic clr_b_align;
  logic clr_b_pair;

  logic next_proc_ack;
  logic next_fab_ack;
  logic [7:0] next_proc_rdata;
  logic [7:0] next_fab_rdata;

  // Same 18-bit map for both ports; unmapped gives SEL_NONE
  function automatic serdes_status_pkg::reg_sel_t decode_addr(input logic [17:0] addr);
    serdes_status_pkg::reg_sel_t result;
    result = serdes_status_pkg::SEL_NONE;
    if (addr == serdes_status_pkg::QUAD_A_LINK_SYNC_STATE) begin
      result = serdes_status_pkg::SEL_A_SYNC;
    end else if (addr == serdes_status_pkg::QUAD_A_ALIGNMENT_STATUS) begin
      result = serdes_status_pkg::SEL_A_ALIGN;
    end else if (addr == serdes_status_pkg::QUAD_A_PAIR_SYNC_STATUS) begin
      result = serdes_status_pkg::SEL_A_PAIR;
    end else if (addr == serdes_status_pkg::QUAD_B_LINK_SYNC_STATE) begin
      result = serdes_status_pkg::SEL_B_SYNC;
    end else if (addr == serdes_status_pkg::QUAD_B_ALIGNMENT_STATUS) begin
      result = serdes_status_pkg::SEL_B_ALIGN;
    end else if (addr == serdes_status_pkg::QUAD_B_PAIR_SYNC_STATUS) begin
      result = serdes_status_pkg::SEL_B_PAIR;
    end else if (addr == serdes_status_pkg::QUAD_B_SPARE) begin
      result = serdes_status_pkg::SEL_B_SPARE;
    end
    return result;
  endfunction : decode_addr

  // ****************************************
  // Request capture
  // ****************************************
  port_request_latch u_request (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .take(take),
    .proc_req(proc_req),
    .proc_write(proc_write),
    .proc_addr(proc_addr),
    .fab_req(fab_req),
    .fab_write(fab_write),
    .fab_addr(fab_addr),
    .any_req(any_req),
    .held_from_fab(held_from_fab),
    .held_write(held_write),
    .held_addr(held_addr)
  );

  // ****************************************
  // Per-quad status copies
  // ****************************************
  quad_status_capture u_quad_a (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .link_sync_state_first(quad_a_link_sync_first),
    .link_sync_state_second(quad_a_link_sync_second),
    .word_align_ok_first(quad_a_word_align_first),
    .word_align_ok_second(quad_a_word_align_second),
    .lane_align_ok_first(quad_a_lane_align_first),
    .lane_align_ok_second(quad_a_lane_align_second),
    .pair_fifo_overflow(quad_a_pair_fifo_overflow),
    .pair_sync_lost(quad_a_pair_sync_lost),
    .clear_sync(clr_a_sync),
    .clear_align(clr_a_align),
    .clear_pair(clr_a_pair),
    .sync_value(a_sync),
    .align_value(a_align),
    .pair_value(a_pair)
  );

  quad_status_capture u_quad_b (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .link_sync_state_first(quad_b_link_sync_first),
    .link_sync_state_second(quad_b_link_sync_second),
    .word_align_ok_first(quad_b_word_align_first),
    .word_align_ok_second(quad_b_word_align_second),
    .lane_align_ok_first(quad_b_lane_align_first),
    .lane_align_ok_second(quad_b_lane_align_second),
    .pair_fifo_overflow(quad_b_pair_fifo_overflow),
    .pair_sync_lost(quad_b_pair_sync_lost),
    .clear_sync(clr_b_sync),
    .clear_align(clr_b_align),
    .clear_pair(clr_b_pair),
    .sync_value(b_sync),
    .align_value(b_align),
    .pair_value(b_pair)
  );

  // ****************************************
  // Decode, read mux and clear strobes
  // ****************************************
  always_comb begin
    sel = decode_addr(held_addr);
    reading = (state == ST_ACCESS) && !held_write;
    case (sel)
      serdes_status_pkg::SEL_A_SYNC: read_value = a_sync;
      serdes_status_pkg::SEL_A_ALIGN: read_value = a_align;
      serdes_status_pkg::SEL_A_PAIR: read_value = a_pair;
      serdes_status_pkg::SEL_B_SYNC: read_value = b_sync;
      serdes_status_pkg::SEL_B_ALIGN: read_value = b_align;
      serdes_status_pkg::SEL_B_PAIR: read_value = b_pair;
      default: read_value = serdes_status_pkg::STATUS_RESET;
    endcase
    if (!reading) begin
      read_value = serdes_status_pkg::STATUS_RESET;
    end
    clr_a_sync = reading && (sel == serdes_status_pkg::SEL_A_SYNC);
    clr_a_align = reading && (sel == serdes_status_pkg::SEL_A_ALIGN);
    clr_a_pair = reading && (sel == serdes_status_pkg::SEL_A_PAIR);
    clr_b_sync = reading && (sel == serdes_status_pkg::SEL_B_SYNC);
    clr_b_align = reading && (sel == serdes_status_pkg::SEL_B_ALIGN);
    clr_b_pair = reading && (sel == serdes_status_pkg::SEL_B_PAIR);
  end

  // ****************************************
  // Access sequencer
  // ****************************************
  always_comb begin
    next_state = state;
    take = 1'b0;
    case (state)
      ST_IDLE: begin
        if (any_req) begin
          take = 1'b1;
          next_state = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        next_state = ST_RELEASE;
      end
      ST_RELEASE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // Answer registers
  // ****************************************
  always_comb begin
    next_proc_ack = (state == ST_ACCESS) && !held_from_fab;
    next_fab_ack = (state == ST_ACCESS) && held_from_fab;
    next_proc_rdata = next_proc_ack ? read_value : 8'h00;
    next_fab_rdata = next_fab_ack ? read_value : 8'h00;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      proc_ack <= 1'b0;
      fab_ack <= 1'b0;
      proc_rdata <= 8'h00;
      fab_rdata <= 8'h00;
    end else begin
      state <= next_state;
      proc_ack <= next_proc_ack;
      fab_ack <= next_fab_ack;
      proc_rdata <= next_proc_rdata;
      fab_rdata <= next_fab_rdata;
    end
  end

endmodule : serdes_link_status_regs

// ===== testbench/serdes_link_status_regs_assertions.sv
// Purpose: Port checker for the transceiver status register bank.
// Assumes: Single clock domain, asynchronous active-low reset.
// Notes: Acks and read data are looked at on the edge that samples them high.
`timescale 1ns/1ps
module serdes_link_status_regs_assertions (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic proc_req,
  input wire logic proc_write,
  input wire logic [17:0] proc_addr,
  input wire logic proc_ack,
  input wire logic [7:0] proc_rdata,
  input wire logic fab_req,
  input wire logic fab_ack,
  input wire logic [7:0] fab_rdata,
  input wire logic [1:0] quad_a_link_sync_first
);
  // ****************************************
  // Sequences and properties
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence any_ack;
    proc_ack || fab_ack;
  endsequence
  sequence proc_read_of(logic [17:0] a);
    proc_ack && !$past(proc_write) && $past(proc_addr) == a;
  endsequence
  chk_ack_then_quiet: assert property (any_ack |=> (!proc_ack && !fab_ack) [*2])
    else $error("ack spacing too short");
  chk_proc_ack_cause: assert property (proc_ack |-> $past(proc_req, 2) && $past(proc_req))
    else $error("processor ack without request");
  chk_fab_ack_cause: assert property (fab_ack |-> $past(fab_req, 2) && $past(fab_req))
    else $error("fabric ack without request");
  chk_rdata_idle_zero: assert property ((proc_ack || proc_rdata == 8'h00) && (fab_ack || fab_rdata == 8'h00))
    else $error("read data outside ack");
  chk_write_no_data: assert property (proc_ack && $past(proc_write) |-> proc_rdata == 8'h00)
    else $error("write returned data");
  chk_spare_reads_zero: assert property (proc_read_of(serdes_status_pkg::QUAD_B_SPARE) |-> proc_rdata == 8'h00)
    else $error("spare register not zero");
  chk_sync_low_zero: assert property ((proc_read_of(serdes_status_pkg::QUAD_A_LINK_SYNC_STATE) or
    proc_read_of(serdes_status_pkg::QUAD_B_LINK_SYNC_STATE)) |-> proc_rdata[3:0] == 4'h0)
    else $error("sync register reserved bits set");
  chk_align_gaps_zero: assert property ((proc_read_of(serdes_status_pkg::QUAD_A_ALIGNMENT_STATUS) or
    proc_read_of(serdes_status_pkg::QUAD_B_ALIGNMENT_STATUS)) |-> (proc_rdata & 8'h33) == 8'h00)
    else $error("alignment register reserved bits set");
  chk_pair_gaps_zero: assert property ((proc_read_of(serdes_status_pkg::QUAD_A_PAIR_SYNC_STATUS) or
    proc_read_of(serdes_status_pkg::QUAD_B_PAIR_SYNC_STATUS)) |-> (proc_rdata & 8'hed) == 8'h00)
    else $error("pair register reserved bits set");
  chk_live_code_kept: assert property (proc_read_of(serdes_status_pkg::QUAD_A_LINK_SYNC_STATE) ##0
    ($past(quad_a_link_sync_first, 2) == 2'h1 && $past(quad_a_link_sync_first, 3) == 2'h1)
    |-> proc_rdata[5:4] == 2'h1)
    else $error("live sync code lost");
endmodule : serdes_link_status_regs_assertions

// ===== testbench/host_port_model.sv
// Purpose: Host master driving the processor and fabric ports.
// Assumes: Requests change on the falling edge of clk_sys.
// Notes: Released address and write lines show inverted values.
`timescale 1ns/1ps
module host_port_model (
  input wire logic clk_sys,
  output logic proc_req,
  output logic proc_write,
  output logic [17:0] proc_addr,
  input wire logic proc_ack,
  input wire logic [7:0] proc_rdata,
  output logic fab_req,
  output logic fab_write,
  output logic [17:0] fab_addr,
  input wire logic fab_ack,
  input wire logic [7:0] fab_rdata
);
  logic req [2] = '{1'b0, 1'b0};
  logic wr [2] = '{1'b0, 1'b0};
  logic [17:0] adr [2] = '{18'h0, 18'h0};
  assign proc_req = req[0];
  assign proc_write = wr[0];
  assign proc_addr = adr[0];
  assign fab_req = req[1];
  assign fab_write = wr[1];
  assign fab_addr = adr[1];
  task automatic access(input int p, input logic w, input logic [17:0] a,
                        output logic [7:0] d, output logic ok);
    int n;
    n = 0;
    @(negedge clk_sys);
    req[p] = 1'b1;
    wr[p] = w;
    adr[p] = a;
    do begin
      @(posedge clk_sys);
      n++;
    end while ((p ? fab_ack : proc_ack) !== 1'b1 && n < 40);
    d = p ? fab_rdata : proc_rdata;
    ok = n < 40;
    @(negedge clk_sys);
    req[p] = 1'b0;
    wr[p] = ~w;
    adr[p] = ~a;
  endtask : access
endmodule : host_port_model

// ===== testbench/test_serdes_link_status_regs.sv
// Purpose: Self-checking bench of the status register bank.
// Assumes: Inputs change on the falling edge; 50 MHz clock.
// Notes: Bench model tracks the six status registers and clears each on read, reloading live sync codes; spare and unmapped reads expect zero.
`timescale 1ns/1ps
module test_serdes_link_status_regs;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic proc_req, proc_write, proc_ack, fab_req, fab_write, fab_ack;
  logic [17:0] proc_addr, fab_addr;
  logic [7:0] proc_rdata, fab_rdata;
  logic [1:0] s1 [2] = '{2'h0, 2'h0};
  logic [1:0] s2 [2] = '{2'h0, 2'h0};
  logic [5:0] ev [2] = '{6'h0, 6'h0};
  logic [17:0] adr [8];
  int m [6];
  int fails = 0;
  int n_tests = 0;
  int cycles = 0;
  always #10 clk_sys = ~clk_sys;
  serdes_link_status_regs i_serdes_link_status_regs (
    .clk_sys(clk_sys), .arst_n(arst_n), .proc_req(proc_req), .proc_write(proc_write),
    .proc_addr(proc_addr), .proc_ack(proc_ack), .proc_rdata(proc_rdata), .fab_req(fab_req),
    .fab_write(fab_write), .fab_addr(fab_addr), .fab_ack(fab_ack), .fab_rdata(fab_rdata),
    .quad_a_link_sync_first(s1[0]), .quad_a_link_sync_second(s2[0]),
    .quad_a_word_align_first(ev[0][0]), .quad_a_word_align_second(ev[0][1]),
    .quad_a_lane_align_first(ev[0][2]), .quad_a_lane_align_second(ev[0][3]),
    .quad_a_pair_fifo_overflow(ev[0][4]), .quad_a_pair_sync_lost(ev[0][5]),
    .quad_b_link_sync_first(s1[1]), .quad_b_link_sync_second(s2[1]),
    .quad_b_word_align_first(ev[1][0]), .quad_b_word_align_second(ev[1][1]),
    .quad_b_lane_align_first(ev[1][2]), .quad_b_lane_align_second(ev[1][3]),
    .quad_b_pair_fifo_overflow(ev[1][4]), .quad_b_pair_sync_lost(ev[1][5]));
  host_port_model i_host_port_model (
    .clk_sys(clk_sys), .proc_req(proc_req), .proc_write(proc_write), .proc_addr(proc_addr),
    .proc_ack(proc_ack), .proc_rdata(proc_rdata), .fab_req(fab_req), .fab_write(fab_write),
    .fab_addr(fab_addr), .fab_ack(fab_ack), .fab_rdata(fab_rdata));
  // ****************************************
  // Model, drivers and compare
  // ****************************************
  function automatic bit code_ok(input logic [1:0] c);
    return c == 2'h1 || c == 2'h2;
  endfunction : code_ok
  function automatic int live(input int r);
    int q;
    q = r / 3;
    if (r % 3 != 0) return 0;
    return (code_ok(s1[q]) ? int'({s1[q], 4'h0}) : 0) | (code_ok(s2[q]) ? int'({s2[q], 6'h0}) : 0);
  endfunction : live
  task automatic check(input logic [7:0] got, input logic [7:0] want);
    n_tests++;
    if (got !== want) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask : check
  task automatic stim(input int q, input logic [1:0] c1, input logic [1:0] c2,
                      input logic [5:0] e, input bit hold);
    @(negedge clk_sys);
    s1[q] = c1;
    s2[q] = c2;
    ev[q] = e;
    if (code_ok(c1)) m[q * 3] = (m[q * 3] & 'hcf) | int'({c1, 4'h0});
    if (code_ok(c2)) m[q * 3] = (m[q * 3] & 'h3f) | int'({c2, 6'h0});
    m[q * 3 + 1] |= int'({e[3], e[2], 2'b00, e[1], e[0], 2'b00});
    m[q * 3 + 2] |= int'({3'b000, e[5], 2'b00, e[4], 1'b0});
    @(negedge clk_sys);
    ev[q] = 6'h00;
    if (!hold) begin
      s1[q] = 2'h0;
      s2[q] = 2'h0;
    end
  endtask : stim
  task automatic rd(input int p, input int r, input logic w);
    logic [7:0] d;
    logic ok;
    int want;
    want = (w || r > 5) ? 0 : m[r];
    i_host_port_model.access(p, w, adr[r], d, ok);
    if (ok !== 1'b1) fails++;
    check(d, want[7:0]);
    if (!w && r <= 5) m[r] = live(r);
  endtask : rd
  task end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      end_of_test();
    end
  end
  initial begin
    adr = '{serdes_status_pkg::QUAD_A_LINK_SYNC_STATE, serdes_status_pkg::QUAD_A_ALIGNMENT_STATUS,
      serdes_status_pkg::QUAD_A_PAIR_SYNC_STATUS, serdes_status_pkg::QUAD_B_LINK_SYNC_STATE,
      serdes_status_pkg::QUAD_B_ALIGNMENT_STATUS, serdes_status_pkg::QUAD_B_PAIR_SYNC_STATUS,
      serdes_status_pkg::QUAD_B_SPARE, 18'h30806};
    m = '{0, 0, 0, 0, 0, 0};
    void'($urandom(32'h306152de));
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    arst_n = 1'b1;
    for (int r = 0; r < 8; r++) rd(r % 2, r, 1'b0);
    for (int c = 0; c < 8; c++) begin
      stim(c / 4, 2'(c), 2'(~c), 6'h00, 1'b0);
      rd(c % 2, (c / 4) * 3, 1'b0);
    end
    stim(0, 2'h2, 2'h1, 6'h00, 1'b0);
    stim(0, 2'h3, 2'h3, 6'h00, 1'b0);
    rd(1, 0, 1'b0);
    for (int b = 0; b < 6; b++) begin
      stim(b % 2, 2'h0, 2'h0, 6'(1 << b), 1'b0);
      rd(b % 2, (b % 2) * 3 + 1 + b / 4, 1'b1);
      rd(1 - b % 2, (b % 2) * 3 + 1 + b / 4, 1'b0);
      rd(b % 2, (b % 2) * 3 + 1 + b / 4, 1'b0);
    end
    stim(0, 2'h1, 2'h2, 6'h00, 1'b1);
    rd(0, 0, 1'b0);
    rd(1, 0, 1'b0);
    stim(0, 2'h0, 2'h0, 6'h00, 1'b0);
    stim(0, 2'h0, 2'h0, 6'h0c, 1'b0);
    stim(1, 2'h0, 2'h0, 6'h30, 1'b0);
    fork
      rd(0, 1, 1'b0);
      rd(1, 5, 1'b0);
    join
    repeat (40) begin
      stim($urandom % 2, 2'($urandom), 2'($urandom), 6'($urandom), 1'b0);
      rd($urandom % 2, $urandom % 8, $urandom % 4 == 0);
    end
    stim(1, 2'h1, 2'h2, 6'h3f, 1'b0);
    @(negedge clk_sys);
    arst_n = 1'b0;
    m = '{0, 0, 0, 0, 0, 0};
    @(negedge clk_sys);
    arst_n = 1'b1;
    for (int r = 0; r < 6; r++) rd(1, r, 1'b0);
    end_of_test();
  end
endmodule : test_serdes_link_status_regs
bind serdes_link_status_regs serdes_link_status_regs_assertions i_serdes_link_status_regs_assertions (
  .clk_sys, .arst_n, .proc_req, .proc_write, .proc_addr, .proc_ack, .proc_rdata,
  .fab_req, .fab_ack, .fab_rdata, .quad_a_link_sync_first);
